// [hdl/sswd_consts.svh]
// timing and reset constants of the supply supervisor watchdog
// assumes a single 20 MHz block clock
`ifndef SSWD_CONSTS_SVH
`define SSWD_CONSTS_SVH

// block clock period in ns
`define SSWD_CLK_PERIOD_NS      50
// default watchdog period in us, stands in for the timing capacitor
`define SSWD_WD_PERIOD_US       200
// default reset hold period in us
`define SSWD_RST_HOLD_US        20
`define SSWD_WD_CYCLES          ((`SSWD_WD_PERIOD_US * 1000) / `SSWD_CLK_PERIOD_NS)
`define SSWD_RST_CYCLES         (((`SSWD_RST_HOLD_US * 1000) + `SSWD_CLK_PERIOD_NS - 1) / `SSWD_CLK_PERIOD_NS)
`define SSWD_CNT_W              24
`define SSWD_FAULT_N_RESET      1'h1
`define SSWD_SYS_RST_N_RESET    1'h0

`endif

// [hdl/sswd_pkg.sv]
// types of the supply supervisor watchdog
// assumes nothing beyond the constants header
`default_nettype none
`include "sswd_consts.svh"

package sswd_pkg;
    typedef enum logic [1:0] {
        SSWD_HOLD,
        SSWD_RUN,
        SSWD_OFF
    } sswd_state_t;

    // kick input as seen at the pin: level and floating flag
    typedef struct packed {
        logic level;
        logic floating;
    } sswd_kick_t;

    // the two status outputs
    typedef struct packed {
        logic sys_rst_n;
        logic watchdog_fault_n;
    } sswd_out_t;
endpackage : sswd_pkg

`default_nettype wire

// [hdl/sswd_top.sv]
// watchdog and reset-cause logic of a multi-supply supervisor
// assumes kick and undervoltage inputs synchronous to clock
`default_nettype none
`include "sswd_consts.svh"

// Overview of operation
// - A full watchdog period without a kick edge latches the fault low and pulls reset low together.
// - While reset is low the kick input changes neither reset nor the fault.
// - After a timeout reset stays low for at least one reset hold period.
// - Undervoltage clears the fault latch high and clears the watchdog timer.
// - Without a clear the block keeps alternating watchdog periods and reset hold periods.
// - The fault stays low until a kick edge or an undervoltage clears it.
// - A floating kick input keeps the watchdog timer cleared and leaves the fault alone.
// - A floating kick input does not change the reset hold length.
// - A kick input driven again after floating, with reset high, starts a fresh full watchdog period.
// - A kick edge while reset is high clears a latched low fault.
// - The watchdog timer starts when reset goes high.
// - Grounding the timing node turns the watchdog off from the next cycle on; undervoltage forces the fault high.
module sswd_top
#(
    // cycle counts replace the timing capacitors
    parameter int unsigned WD_CYCLES  = `SSWD_WD_CYCLES,
    parameter int unsigned RST_CYCLES = `SSWD_RST_CYCLES
)
(
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rstn,
    // supervised processor side
    input  wire sswd_pkg::sswd_kick_t kick_input,
    // supply comparators and timing node
    input  wire logic                undervoltage,
    input  wire logic                watchdog_timing_node_grounded,
    // status outputs
    output var sswd_pkg::sswd_out_t   status
);
    import sswd_pkg::*;

    localparam logic [`SSWD_CNT_W-1:0] WD_LAST  = `SSWD_CNT_W'(WD_CYCLES - 1);
    localparam logic [`SSWD_CNT_W-1:0] RST_LAST = `SSWD_CNT_W'(RST_CYCLES - 1);

    sswd_state_t             state;
    logic [`SSWD_CNT_W-1:0]  count;
    logic                    kick_prev;
    logic                    kick_prev_valid;
    logic                    kick_edge;
    logic                    timeout;
    logic                    hold_done;
    logic                    sys_rst_n;
    logic                    watchdog_fault_n;
    logic [`SSWD_CNT_W-1:0]  low_cycles;

    // ************************************************************
    // kick edge detection
    // ************************************************************
    // an edge counts only between two driven samples
    assign kick_edge = !kick_input.floating && kick_prev_valid && (kick_input.level != kick_prev);

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            kick_prev       <= 1'h0;
            kick_prev_valid <= 1'h0;
        end
        else
        begin
            kick_prev       <= kick_input.level;
            kick_prev_valid <= !kick_input.floating;
        end
    end

    assign timeout   = (state == SSWD_RUN) && (count == WD_LAST) && !kick_edge
                       && !kick_input.floating && !undervoltage;
    assign hold_done = (state == SSWD_HOLD) && (count == RST_LAST) && !undervoltage;

    // ************************************************************
    // period sequencer
    // ************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= SSWD_HOLD;
            count <= `SSWD_CNT_W'h0;
        end
        else if (undervoltage)
        begin
            state <= SSWD_HOLD;
            count <= `SSWD_CNT_W'h0;
        end
        else
        begin
            case (state)
                SSWD_HOLD:
                begin
                    if (hold_done)
                    begin
                        state <= watchdog_timing_node_grounded ? SSWD_OFF : SSWD_RUN;
                        count <= `SSWD_CNT_W'h0;
                    end
                    else
                    begin
                        count <= count + `SSWD_CNT_W'h1;
                    end
                end
                SSWD_RUN:
                begin
                    if (watchdog_timing_node_grounded)
                    begin
                        state <= SSWD_OFF;
                        count <= `SSWD_CNT_W'h0;
                    end
                    else if (kick_input.floating || kick_edge)
                    begin
                        count <= `SSWD_CNT_W'h0;
                    end
                    else if (timeout)
                    begin
                        state <= SSWD_HOLD;
                        count <= `SSWD_CNT_W'h0;
                    end
                    else
                    begin
                        count <= count + `SSWD_CNT_W'h1;
                    end
                end
                SSWD_OFF:
                begin
                    count <= `SSWD_CNT_W'h0;
                    if (!watchdog_timing_node_grounded)
                    begin
                        state <= SSWD_RUN;
                    end
                end
                default:
                begin
                    state <= SSWD_HOLD;
                    count <= `SSWD_CNT_W'h0;
                end
            endcase
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sys_rst_n <= `SSWD_SYS_RST_N_RESET;
        end
        else if (undervoltage || timeout)
        begin
            sys_rst_n <= 1'h0;
        end
        else if (hold_done)
        begin
            sys_rst_n <= 1'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            watchdog_fault_n <= `SSWD_FAULT_N_RESET;
        end
        else if (undervoltage)
        begin
            watchdog_fault_n <= 1'h1;
        end
        else if (timeout)
        begin
            watchdog_fault_n <= 1'h0;
        end
        else if (kick_edge && sys_rst_n)
        begin
            watchdog_fault_n <= 1'h1;
        end
    end

    // one process per flop keeps each output bit single-driven
    assign status = sswd_out_t'{sys_rst_n: sys_rst_n, watchdog_fault_n: watchdog_fault_n};

    // low time counted in full
    // saturates so a very long undervoltage cannot wrap it
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            low_cycles <= `SSWD_CNT_W'h0;
        end
        else if (sys_rst_n)
        begin
            low_cycles <= `SSWD_CNT_W'h0;
        end
        else if (low_cycles != {`SSWD_CNT_W{1'h1}})
        begin
            low_cycles <= low_cycles + `SSWD_CNT_W'h1;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    chk_fault_with_reset: assert property (@(posedge clock) disable iff (!rstn)
        $fell(status.watchdog_fault_n) |-> $fell(status.sys_rst_n))
        else $error("fault fell without reset falling");

    chk_reset_ignores_kick: assert property (@(posedge clock) disable iff (!rstn)
        (!status.sys_rst_n && !$past(undervoltage) && !$past(status.sys_rst_n) && !status.watchdog_fault_n)
        |=> (!status.watchdog_fault_n || undervoltage || $past(undervoltage)) || status.sys_rst_n)
        else $error("fault cleared while reset low");

    chk_hold_length: assert property (@(posedge clock) disable iff (!rstn)
        ($fell(status.sys_rst_n) && !undervoltage) ##1 (!undervoltage)[*2] |-> !status.sys_rst_n)
        else $error("reset hold too short");

    chk_hold_full: assert property (@(posedge clock) disable iff (!rstn)
        $rose(status.sys_rst_n) |-> low_cycles >= `SSWD_CNT_W'(RST_CYCLES))
        else $error("reset released before a full hold");

    chk_uv_clears: assert property (@(posedge clock) disable iff (!rstn)
        undervoltage |=> status.watchdog_fault_n && !status.sys_rst_n && count == `SSWD_CNT_W'h0)
        else $error("undervoltage did not clear");

    chk_fault_sticks: assert property (@(posedge clock) disable iff (!rstn)
        (!status.watchdog_fault_n && !undervoltage && !kick_edge) |=> !status.watchdog_fault_n)
        else $error("fault cleared without cause");

    chk_float_clears: assert property (@(posedge clock) disable iff (!rstn)
        (state == SSWD_RUN && kick_input.floating && !undervoltage && !watchdog_timing_node_grounded)
        |=> count == `SSWD_CNT_W'h0 && $stable(status.watchdog_fault_n))
        else $error("floating kick did not clear timer");

    chk_edge_clears: assert property (@(posedge clock) disable iff (!rstn)
        (kick_edge && status.sys_rst_n && !undervoltage) |=> status.watchdog_fault_n)
        else $error("kick edge did not clear fault");

    chk_timer_start: assert property (@(posedge clock) disable iff (!rstn)
        ($rose(status.sys_rst_n) && !watchdog_timing_node_grounded) |-> state == SSWD_RUN && count == `SSWD_CNT_W'h0)
        else $error("timer not started on release");

    chk_grounded_off: assert property (@(posedge clock) disable iff (!rstn)
        (state == SSWD_OFF && watchdog_timing_node_grounded) |=> status.sys_rst_n || undervoltage
            || $past(undervoltage))
        else $error("reset while watchdog disabled");
endmodule : sswd_top

`default_nettype wire

// [bench/sswd_cpu_model.sv]
// supervised processor model that drives the kick pin
// assumes the bench commands when to toggle and when to float
`default_nettype none

module sswd_cpu_model
(
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rstn,
    // commands from the bench
    input  wire logic                kick_en,
    input  wire logic                float_req,
    input  wire logic [3:0]          half_period,
    // kick pin
    output var sswd_pkg::sswd_kick_t kick
);
    timeunit 1ns;
    timeprecision 1ps;
    import sswd_pkg::*;
    logic [3:0] cnt;
    logic       drive_level;

    // toggle only, fault and reset read apart
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt         <= 4'h0;
            drive_level <= 1'h0;
        end
        else
        begin
            cnt <= (kick_en && cnt < half_period) ? cnt + 4'h1 : 4'h0;
            if (kick_en && !float_req && cnt >= half_period)
                drive_level <= ~drive_level;
        end
    end

    // released pin shows a level that changes every cycle
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            kick <= '0;
        end
        else
        begin
            kick.floating <= float_req;
            kick.level    <= float_req ? ~kick.level : drive_level;
        end
    end
endmodule : sswd_cpu_model

`default_nettype wire

// [bench/sswd_top_tb.sv]
// self-checking bench of the supervisor watchdog
// assumes the processor model of this folder
`default_nettype none

module sswd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sswd_pkg::*;
    localparam int WD = 8;
    localparam int RC = 4;
    logic clock = 1'h0, rstn = 1'h0, undervoltage = 1'h0, grounded = 1'h0;
    logic kick_en = 1'h0, float_req = 1'h0;
    logic [3:0] half_period = 4'h2;
    sswd_kick_t kick;
    sswd_out_t  status;
    int miscompares = 0, comparisons = 0, n, bad;

    sswd_top #(.WD_CYCLES(WD), .RST_CYCLES(RC)) sswd_top_inst (.clock(clock), .rstn(rstn),
        .kick_input(kick), .undervoltage(undervoltage), .watchdog_timing_node_grounded(grounded), .status(status));
    sswd_cpu_model sswd_cpu_model_inst (.clock(clock), .rstn(rstn), .kick_en(kick_en), .float_req(float_req),
        .half_period(half_period), .kick(kick));

    initial forever #25 clock = ~clock;

    task automatic tick();
        @(posedge clock) #1;
    endtask : tick

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // bounded wait for reset output level, counts edges
    task automatic wait_rst(input logic want, output int k);
        k = 0;
        while (status.sys_rst_n !== want && k < 200)
        begin
            tick();
            k++;
        end
    endtask : wait_rst

    task automatic run_high(input int k);
        bad = 0;
        repeat (k)
        begin
            tick();
            if (status.sys_rst_n !== 1'h1) bad++;
        end
    endtask : run_high

    task automatic t_timeout();
        wait_rst(1'h0, n);
        check(n, WD);
        check(status.watchdog_fault_n, 1'h0);
        wait_rst(1'h1, n);
        check(n, RC);
        check(status.watchdog_fault_n, 1'h0);
        $display("test timeout done");
    endtask : t_timeout

    task automatic t_cycle();
        wait_rst(1'h0, n);
        check(n, WD);
        kick_en = 1'h1;
        half_period = 4'h0;
        tick();
        tick();
        kick_en = 1'h0;
        half_period = 4'h2;
        float_req = 1'h1;
        wait_rst(1'h1, n);
        float_req = 1'h0;
        check(n + 2, RC);
        check(status.watchdog_fault_n, 1'h0);
        $display("test cycle done");
    endtask : t_cycle

    task automatic t_clear();
        kick_en = 1'h1;
        run_high(3 * WD);
        check(bad, 0);
        check(status.watchdog_fault_n, 1'h1);
        $display("test clear done");
    endtask : t_clear

    task automatic t_float();
        kick_en = 1'h0;
        float_req = 1'h1;
        run_high(3 * WD);
        check(bad, 0);
        check(status.watchdog_fault_n, 1'h1);
        float_req = 1'h0;
        wait_rst(1'h0, n);
        check(n, WD + 1);
        check(status.watchdog_fault_n, 1'h0);
        $display("test float done");
    endtask : t_float

    task automatic t_uv();
        undervoltage = 1'h1;
        tick();
        check(status, 2'h1);
        repeat (3) tick();
        undervoltage = 1'h0;
        wait_rst(1'h1, n);
        check(n, RC);
        check(status.watchdog_fault_n, 1'h1);
        $display("test undervoltage done");
    endtask : t_uv

    task automatic t_gnd();
        grounded = 1'h1;
        run_high(3 * WD);
        check(bad, 0);
        grounded = 1'h0;
        wait_rst(1'h0, n);
        check(n, WD + 1);
        check(status.watchdog_fault_n, 1'h0);
        grounded = 1'h1;
        wait_rst(1'h1, n);
        check(n, RC);
        run_high(3 * WD);
        check(bad, 0);
        check(status.watchdog_fault_n, 1'h0);
        undervoltage = 1'h1;
        tick();
        undervoltage = 1'h0;
        repeat (3 * WD) tick();
        check(status.watchdog_fault_n, 1'h1);
        check(status.sys_rst_n, 1'h1);
        grounded = 1'h0;
        $display("test grounded done");
    endtask : t_gnd

    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (8) @(posedge clock);
        #1 rstn = 1'h1;
        wait_rst(1'h1, n);
        t_timeout();
        t_cycle();
        t_clear();
        t_float();
        t_uv();
        t_gnd();
        summarize();
    end

    // whole run needs well under two thousand cycles
    initial
    begin
        #(50 * 5000);
        miscompares++;
        summarize();
    end
endmodule : sswd_top_tb

`default_nettype wire
